/* pkg/reset_init_pkg.sv */
// constants, register map and states of the reset and suspend sequencer
package reset_init_pkg;

	localparam int unsigned COUNT_W = 21;
	localparam int unsigned ADDR_W = 8;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
	localparam logic [ADDR_W-1:0] ACCUM_OFFSET = 8'h08;
	localparam logic [ADDR_W-1:0] DATA_D_OFFSET = 8'h0C;
	localparam logic [ADDR_W-1:0] SELECTOR_OFFSET = 8'h10;
	localparam logic [ADDR_W-1:0] SEG_LIMIT_OFFSET = 8'h14;
	localparam logic [ADDR_W-1:0] FETCH_OFFSET = 8'h18;
	localparam logic [ADDR_W-1:0] SEG_BASE_OFFSET = 8'h1C;
	localparam logic [3:0] REGION_PAGE = 4'h2;

	////////////////////////////////////////////////////////////////////////
	// control register fields
	localparam int unsigned CTRL_SELFTEST_BIT = 0;
	localparam int unsigned CTRL_INIT_DONE_BIT = 1;
	localparam int unsigned CTRL_HALT_BIT = 2;
	localparam int unsigned CTRL_CACHE_BIT = 3;
	localparam int unsigned CTRL_PAGING_BIT = 4;
	localparam int unsigned CTRL_PROT_BIT = 5;
	localparam int unsigned CTRL_W = 6;

	// status register fields
	localparam int unsigned STAT_MASK_BIT = 8;
	localparam int unsigned STAT_SELFTEST_BIT = 9;
	localparam int unsigned STAT_PAGING_BIT = 10;
	localparam int unsigned STAT_CACHE_BIT = 11;
	localparam int unsigned STAT_REAL_BIT = 12;

	////////////////////////////////////////////////////////////////////////
	// initial values
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
	localparam logic [31:0] FETCH_VECTOR = 32'hFFFFFFF0;
	localparam logic [31:0] ACCUM_PASS = 32'h00000000;
	localparam logic [31:0] ACCUM_FAIL = 32'hFFFFFFFF;
	localparam logic [15:0] DATA_D_BASE = 16'h0400;
	localparam logic [15:0] CODE_SELECTOR_INIT = 16'hF000;
	localparam logic [15:0] DATA_SELECTOR_INIT = 16'h0000;
	localparam logic [31:0] SEG_BASE_INIT = 32'h00000000;
	localparam logic [15:0] SEG_LIMIT_INIT = 16'hFFFF;
	localparam logic [15:0] NONCACHE_ONE_INIT = 16'h000F;
	localparam logic [15:0] NONCACHE_OTHER_INIT = 16'h0000;
	localparam int unsigned UPPER_ADDR_MSB = 31;
	localparam int unsigned UPPER_ADDR_LSB = 20;

	////////////////////////////////////////////////////////////////////////
	// post-reset delays in double-rate clock cycles
	localparam int unsigned RESET_DELAY_MIN_CYCLES = 350;
	localparam int unsigned RESET_DELAY_MAX_CYCLES = 450;
	localparam int unsigned RESET_DELAY_CYCLES = (RESET_DELAY_MIN_CYCLES +
		RESET_DELAY_MAX_CYCLES) / 2;
	localparam int unsigned SELFTEST_EXTRA_CYCLES = (1 << 20) + 60;

	typedef enum logic [4:0] {
		ST_RESET = 5'b00001,
		ST_DELAY = 5'b00010,
		ST_RUN = 5'b00100,
		ST_DRAIN = 5'b01000,
		ST_SUSPENDED = 5'b10000
	} seq_state_t;

endpackage

/* src/post_reset_counter.sv */
// down counter that times the gap between reset release and first fetch
module post_reset_counter
	import reset_init_pkg::*;
#(
	parameter int unsigned WIDTH = COUNT_W
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic load_in,
	input wire logic [WIDTH-1:0] load_value_in,
	input wire logic count_en_in,
	output logic done_out
);

	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	wire count_zero = (count_reg == '0);

	assign count_next = load_in ? load_value_in :
		(count_en_in && !count_zero) ? count_reg - WIDTH'(1) : count_reg;
	assign done_out = count_zero;

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

endmodule

/* src/noncache_region_store.sv */
// non-cacheable region registers with registered read port
module noncache_region_store
	import reset_init_pkg::*;
#(
	parameter int unsigned ENTRIES = 4,
	parameter int unsigned WIDTH = 16
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic init_in,
	input wire logic wr_en_in,
	input wire logic [$clog2(ENTRIES)-1:0] wr_index_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic rd_en_in,
	input wire logic [$clog2(ENTRIES)-1:0] rd_index_in,
	output logic [WIDTH-1:0] rd_data_out
);

	logic [WIDTH-1:0] entry_reg [ENTRIES];
	logic [WIDTH-1:0] rd_data_reg;

	genvar gi;
	generate
		for (gi = 0; gi < ENTRIES; gi++) begin : g_entry
			localparam logic [WIDTH-1:0] INIT_VALUE =
				(gi == 0) ? WIDTH'(NONCACHE_ONE_INIT) : WIDTH'(NONCACHE_OTHER_INIT);
			wire write_hit = wr_en_in && (wr_index_in == gi);
			always_ff @(posedge clk_sys_in or negedge resetn_in) begin
				if (!resetn_in) begin
					entry_reg[gi] <= INIT_VALUE;
				end else if (init_in) begin
					entry_reg[gi] <= INIT_VALUE;
				end else if (write_hit) begin
					entry_reg[gi] <= wr_data_in;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rd_data_reg <= '0;
		end else if (rd_en_in) begin
			rd_data_reg <= entry_reg[rd_index_in];
		end
	end

	assign rd_data_out = rd_data_reg;

	a_region_init: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		init_in |=> entry_reg[0] == WIDTH'(NONCACHE_ONE_INIT) &&
			entry_reg[ENTRIES-1] == WIDTH'(NONCACHE_OTHER_INIT))
		else $error("region registers not at initial values after reset");

endmodule

/* src/cpu_reset_sequencer.sv */
// reset initialisation, post-reset delay and suspend control of the core
//
// Decided for this implementation: register access over APB and the register offsets.
module cpu_reset_sequencer
	import reset_init_pkg::*;
#(
	parameter int unsigned BASE_DELAY = RESET_DELAY_CYCLES,
	parameter int unsigned SELFTEST_DELAY = SELFTEST_EXTRA_CYCLES,
	parameter logic [7:0] REVISION_ID = 8'h11 // arbitrary value
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic cpu_reset_in,
	input wire logic suspend_request_n_in,
	output logic suspend_ack_n_out,
	input wire logic halt_exec_in,
	input wire logic wake_in,
	input wire logic core_idle_in,
	input wire logic selftest_pass_in,
	input wire logic far_transfer_in,
	input wire logic code_cycle_in,
	input wire logic [31:0] linear_addr_in,
	output logic [31:0] phys_addr_out,
	output logic pipeline_flush_out,
	output logic exec_enable_out,
	output logic bus_start_enable_out,
	output logic core_hold_out,
	output logic bus_abort_out,
	output logic cache_invalidate_out,
	output logic cache_enable_out,
	output logic paging_enable_out,
	output logic real_mode_out,
	output logic fetch_start_out,
	output logic [31:0] fetch_address_out,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out
);

	localparam logic [COUNT_W-1:0] DELAY_PLAIN = COUNT_W'(BASE_DELAY - 1);
	localparam logic [COUNT_W-1:0] DELAY_TEST = COUNT_W'(BASE_DELAY + SELFTEST_DELAY - 1);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic sreq_meta_reg;
	logic sreq_sync_n_reg;

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= 1'b1;
			sreq_meta_reg <= 1'b1;
			sreq_sync_n_reg <= 1'b1;
		end else begin
			rst_meta_reg <= cpu_reset_in;
			rst_sync_reg <= rst_meta_reg;
			sreq_meta_reg <= suspend_request_n_in;
			sreq_sync_n_reg <= sreq_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb decode
	wire bus_setup = psel_in && !penable_in;
	wire bus_access = psel_in && penable_in;
	wire hit_ctrl = (paddr_in == CTRL_OFFSET);
	wire hit_region = (paddr_in[7:4] == REGION_PAGE) && (paddr_in[1:0] == 2'b00);
	wire hit_ro = (paddr_in == STATUS_OFFSET) || (paddr_in == ACCUM_OFFSET) ||
		(paddr_in == DATA_D_OFFSET) || (paddr_in == SELECTOR_OFFSET) ||
		(paddr_in == SEG_LIMIT_OFFSET) || (paddr_in == FETCH_OFFSET) ||
		(paddr_in == SEG_BASE_OFFSET);
	wire mapped = hit_ctrl || hit_region || hit_ro;
	wire wr_commit = bus_access && pwrite_in;
	wire ctrl_write = wr_commit && hit_ctrl;
	wire region_write = wr_commit && hit_region;
	wire init_done_pulse = ctrl_write && pwdata_in[CTRL_INIT_DONE_BIT];
	wire halt_write = ctrl_write && pwdata_in[CTRL_HALT_BIT];

	assign pready_out = 1'b1;
	assign pslverr_out = bus_access && !mapped;

	////////////////////////////////////////////////////////////////////////
	// sequencer state
	seq_state_t state_reg;
	seq_state_t state_next;
	logic [CTRL_W-1:0] ctrl_reg;
	logic by_hw_reg;
	logic delay_done;
	logic selftest_latched_reg;
	wire in_reset = (state_reg == ST_RESET);
	wire in_delay = (state_reg == ST_DELAY);
	wire halt_event = halt_exec_in || halt_write;
	wire hw_request = !sreq_sync_n_reg;
	wire resume = by_hw_reg ? sreq_sync_n_reg : wake_in;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RESET: if (!rst_sync_reg) state_next = ST_DELAY;
			ST_DELAY: if (delay_done) state_next = ST_RUN;
			ST_RUN: if (hw_request || halt_event) state_next = ST_DRAIN;
			ST_DRAIN: if (core_idle_in) state_next = ST_SUSPENDED;
			ST_SUSPENDED: if (resume) state_next = ST_RUN;
			default: state_next = ST_RESET;
		endcase
		if (rst_sync_reg) begin
			state_next = ST_RESET;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_reg <= ST_RESET;
			by_hw_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_reg == ST_RUN && state_next == ST_DRAIN) begin
				by_hw_reg <= hw_request;
			end
		end
	end

	post_reset_counter #(
		.WIDTH(COUNT_W)
	) u_delay (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.load_in(in_reset),
		.load_value_in(ctrl_reg[CTRL_SELFTEST_BIT] ? DELAY_TEST : DELAY_PLAIN),
		.count_en_in(in_delay),
		.done_out(delay_done)
	);

	////////////////////////////////////////////////////////////////////////
	// control bits, mask and initial register values
	logic upper_mask_reg;
	logic far_seen_reg;
	logic [31:0] accum_reg;
	logic [15:0] data_d_reg;
	logic [15:0] code_sel_reg;
	logic [15:0] data_sel_reg;
	logic [15:0] seg_limit_reg;
	logic [31:0] seg_base_reg;
	wire far_first = far_transfer_in && !far_seen_reg && !in_reset;
	wire [15:0] data_d_init = DATA_D_BASE + {8'h00, REVISION_ID};

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_reg <= CTRL_RESET;
			selftest_latched_reg <= 1'b0;
		end else begin
			if (ctrl_write) begin
				ctrl_reg <= pwdata_in[CTRL_W-1:0] & ~(CTRL_W'(1) << CTRL_INIT_DONE_BIT) &
					~(CTRL_W'(1) << CTRL_HALT_BIT);
			end
			if (in_reset) begin
				ctrl_reg[CTRL_CACHE_BIT] <= 1'b0;
				ctrl_reg[CTRL_PAGING_BIT] <= 1'b0;
				ctrl_reg[CTRL_PROT_BIT] <= 1'b0;
				selftest_latched_reg <= ctrl_reg[CTRL_SELFTEST_BIT];
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			far_seen_reg <= 1'b0;
			upper_mask_reg <= 1'b0;
		end else if (in_reset) begin
			far_seen_reg <= 1'b0;
			upper_mask_reg <= 1'b0;
		end else begin
			if (far_first) begin
				far_seen_reg <= 1'b1;
			end
			if (far_first) begin
				upper_mask_reg <= 1'b1;
			end else if (init_done_pulse) begin
				upper_mask_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			accum_reg <= ACCUM_PASS;
			data_d_reg <= DATA_D_BASE;
			code_sel_reg <= CODE_SELECTOR_INIT;
			data_sel_reg <= DATA_SELECTOR_INIT;
			seg_limit_reg <= SEG_LIMIT_INIT;
			seg_base_reg <= SEG_BASE_INIT;
		end else if (in_reset) begin
			data_d_reg <= data_d_init;
			code_sel_reg <= CODE_SELECTOR_INIT;
			data_sel_reg <= DATA_SELECTOR_INIT;
			seg_limit_reg <= SEG_LIMIT_INIT;
			seg_base_reg <= SEG_BASE_INIT;
			accum_reg <= ACCUM_PASS;
		end else if (in_delay && delay_done && selftest_latched_reg) begin
			accum_reg <= selftest_pass_in ? ACCUM_PASS : ACCUM_FAIL;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core-facing outputs
	logic abort_reg;
	logic fetch_start_reg;
	logic [31:0] fetch_addr_reg;
	logic [31:0] phys_addr_reg;
	logic ack_n_reg;
	wire force_low = upper_mask_reg && code_cycle_in;

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			abort_reg <= 1'b0;
			fetch_start_reg <= 1'b0;
			fetch_addr_reg <= FETCH_VECTOR;
			phys_addr_reg <= '0;
			ack_n_reg <= 1'b1;
		end else begin
			abort_reg <= rst_sync_reg && !in_reset;
			fetch_start_reg <= in_delay && delay_done && !rst_sync_reg;
			if (in_reset) begin
				fetch_addr_reg <= FETCH_VECTOR;
			end
			phys_addr_reg <= linear_addr_in;
			if (force_low) begin
				phys_addr_reg[UPPER_ADDR_MSB:UPPER_ADDR_LSB] <= '0;
			end
			ack_n_reg <= (state_next != ST_SUSPENDED);
		end
	end

	assign pipeline_flush_out = state_reg[0];
	assign exec_enable_out = (state_reg == ST_RUN);
	assign bus_start_enable_out = (state_reg == ST_RUN);
	assign core_hold_out = (state_reg == ST_DRAIN) || (state_reg == ST_SUSPENDED);
	assign bus_abort_out = abort_reg;
	assign cache_invalidate_out = abort_reg;
	assign cache_enable_out = ctrl_reg[CTRL_CACHE_BIT];
	assign paging_enable_out = ctrl_reg[CTRL_PAGING_BIT];
	assign real_mode_out = !ctrl_reg[CTRL_PROT_BIT];
	assign fetch_start_out = fetch_start_reg;
	assign fetch_address_out = fetch_addr_reg;
	assign phys_addr_out = phys_addr_reg;
	assign suspend_ack_n_out = ack_n_reg;

	////////////////////////////////////////////////////////////////////////
	// register reads
	logic [31:0] prdata_reg;
	logic region_sel_reg;
	logic [15:0] region_rd;
	logic [31:0] status_word;
	logic [31:0] rd_mux;

	assign status_word = {19'h00000, !ctrl_reg[CTRL_PROT_BIT], ctrl_reg[CTRL_CACHE_BIT],
		ctrl_reg[CTRL_PAGING_BIT], selftest_latched_reg, upper_mask_reg, 3'h0, state_reg};
	assign rd_mux = (paddr_in == CTRL_OFFSET) ? {26'h0000000, ctrl_reg} :
		(paddr_in == STATUS_OFFSET) ? status_word :
		(paddr_in == ACCUM_OFFSET) ? accum_reg :
		(paddr_in == DATA_D_OFFSET) ? {16'h0000, data_d_reg} :
		(paddr_in == SELECTOR_OFFSET) ? {code_sel_reg, data_sel_reg} :
		(paddr_in == SEG_LIMIT_OFFSET) ? {16'h0000, seg_limit_reg} :
		(paddr_in == FETCH_OFFSET) ? fetch_addr_reg :
		(paddr_in == SEG_BASE_OFFSET) ? seg_base_reg : 32'h00000000;

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prdata_reg <= '0;
			region_sel_reg <= 1'b0;
		end else if (bus_setup) begin
			prdata_reg <= rd_mux;
			region_sel_reg <= hit_region;
		end
	end

	assign prdata_out = region_sel_reg ? {16'h0000, region_rd} : prdata_reg;

	noncache_region_store #(
		.ENTRIES(4),
		.WIDTH(16)
	) u_regions (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.init_in(in_reset),
		.wr_en_in(region_write),
		.wr_index_in(paddr_in[3:2]),
		.wr_data_in(pwdata_in[15:0]),
		.rd_en_in(bus_setup && hit_region),
		.rd_index_in(paddr_in[3:2]),
		.rd_data_out(region_rd)
	);

	////////////////////////////////////////////////////////////////////////
	// checks
	logic [COUNT_W-1:0] delay_seen_reg;
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			delay_seen_reg <= '0;
		end else if (in_reset) begin
			delay_seen_reg <= '0;
		end else if (in_delay) begin
			delay_seen_reg <= delay_seen_reg + COUNT_W'(1);
		end
	end

	sequence s_drain_done;
		(state_reg == ST_DRAIN) && core_idle_in && !rst_sync_reg;
	endsequence

	a_flush_in_reset: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		rst_sync_reg |=> pipeline_flush_out && !exec_enable_out && !bus_start_enable_out)
		else $error("core active while reset held");
	a_abort_on_entry: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		rst_sync_reg && !in_reset |=> bus_abort_out && cache_invalidate_out ##1 !bus_abort_out)
		else $error("no single abort pulse on reset entry");
	a_cache_paging_off: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		in_reset ##1 in_reset |-> !cache_enable_out && !paging_enable_out && real_mode_out)
		else $error("cache, paging or protected mode on during reset");
	a_fetch_delay_count: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		fetch_start_out |-> delay_seen_reg ==
			(selftest_latched_reg ? DELAY_TEST : DELAY_PLAIN) + COUNT_W'(1))
		else $error("post-reset delay length wrong");
	a_fetch_vector: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		fetch_start_out |-> fetch_address_out == FETCH_VECTOR && exec_enable_out)
		else $error("first fetch not at reset vector");
	a_upper_lines_low: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		force_low |=> phys_addr_out[UPPER_ADDR_MSB:UPPER_ADDR_LSB] == '0)
		else $error("upper address lines not low on code cycle");
	a_flat_address: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		!force_low |=> phys_addr_out == $past(linear_addr_in))
		else $error("physical address differs from linear address");
	a_ack_after_drain: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		$fell(suspend_ack_n_out) |-> $past(state_reg == ST_DRAIN && core_idle_in))
		else $error("acknowledge before suspend complete");
	a_request_enters: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		(state_reg == ST_RUN) && (hw_request || halt_event) && !rst_sync_reg |=>
			s_drain_done or (state_reg == ST_DRAIN))
		else $error("suspend request not taken");
	a_state_held: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		(state_reg == ST_SUSPENDED) && !resume && !rst_sync_reg && !ctrl_write |=>
			$stable(ctrl_reg) && $stable(accum_reg) && !suspend_ack_n_out)
		else $error("state lost while suspended");
	a_accum_result: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		fetch_start_out && selftest_latched_reg |->
			accum_reg == ($past(selftest_pass_in) ? ACCUM_PASS : ACCUM_FAIL))
		else $error("accumulator does not show self-test result");
	a_init_values: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		in_reset |=> data_d_reg == data_d_init && code_sel_reg == CODE_SELECTOR_INIT &&
			seg_limit_reg == SEG_LIMIT_INIT && seg_base_reg == SEG_BASE_INIT)
		else $error("initial register values wrong");

endmodule

/* tb/sys_partner.sv */
// chipset-side model that drives the reset pin and the suspend request
module sys_partner (
	input wire logic clk_sys_in,
	input wire logic rst_cmd_in,
	input wire logic suspend_request_n_cmd_in,
	input wire logic suspend_ack_n_in,
	output logic cpu_reset_out,
	output logic suspend_request_n_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic ack_seen_reg;
	initial begin
		cpu_reset_out = 1'h1;
		suspend_request_n_out = 1'h1;
		ack_seen_reg = 1'h0;
	end
	always @(posedge clk_sys_in) begin
		cpu_reset_out <= rst_cmd_in;
		// request held low while the command is high, then released once the acknowledge has been seen
		if (suspend_request_n_cmd_in) begin
			suspend_request_n_out <= 1'h0;
		end else if (ack_seen_reg) begin
			suspend_request_n_out <= 1'h1;
			ack_seen_reg <= 1'h0;
		end
		if (!suspend_ack_n_in && !suspend_request_n_out) begin
			ack_seen_reg <= 1'h1;
		end
	end
endmodule

/* tb/tb.sv */
// self-checking bench of the reset and suspend sequencer
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import reset_init_pkg::*;
	localparam int unsigned BASE = 10;
	localparam int unsigned SELF = 20;
	localparam logic [7:0] REV = 8'h3C; // arbitrary value
	int errors = 0, checks_done = 0, base_n;
	logic run = 1'h1, rst_cmd = 1'h1, suspend_request_n_cmd = 1'h0, last_err;
	logic clk_sys_in = 1'h0, resetn_in = 1'h0, cpu_reset_in, suspend_request_n_in;
	logic halt_exec_in = 1'h0, wake_in = 1'h0, core_idle_in = 1'h0, selftest_pass_in = 1'h1;
	logic far_transfer_in = 1'h0, code_cycle_in = 1'h0, psel_in = 1'h0, penable_in = 1'h0;
	logic pwrite_in = 1'h0, pready_out, pslverr_out, suspend_ack_n_out;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] linear_addr_in = 32'h0, pwdata_in = 32'h0, phys_addr_out;
	logic [31:0] prdata_out, fetch_address_out;
	logic pipeline_flush_out, exec_enable_out, bus_start_enable_out, core_hold_out;
	logic bus_abort_out, cache_invalidate_out, cache_enable_out, paging_enable_out;
	logic real_mode_out, fetch_start_out;
	cpu_reset_sequencer #(.BASE_DELAY(BASE), .SELFTEST_DELAY(SELF), .REVISION_ID(REV)) uut (
		.clk_sys_in, .resetn_in, .cpu_reset_in, .suspend_request_n_in, .suspend_ack_n_out,
		.halt_exec_in, .wake_in, .core_idle_in, .selftest_pass_in, .far_transfer_in,
		.code_cycle_in, .linear_addr_in, .phys_addr_out, .pipeline_flush_out,
		.exec_enable_out, .bus_start_enable_out, .core_hold_out, .bus_abort_out,
		.cache_invalidate_out, .cache_enable_out, .paging_enable_out, .real_mode_out,
		.fetch_start_out, .fetch_address_out, .psel_in, .penable_in, .pwrite_in,
		.paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out);
	sys_partner chipset (.clk_sys_in, .rst_cmd_in(rst_cmd), .suspend_request_n_cmd_in(suspend_request_n_cmd),
		.suspend_ack_n_in(suspend_ack_n_out), .cpu_reset_out(cpu_reset_in),
		.suspend_request_n_out(suspend_request_n_in));
	// clock parks low while run is cleared
	initial begin
		forever begin
			#2.5;
			if (run || clk_sys_in) begin
				clk_sys_in = ~clk_sys_in;
			end
		end
	end
	////////////////////////////////////////
	task automatic conclude();
		if (errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	function automatic logic pick(input int w);
		case (w)
			0: return fetch_start_out;
			default: return suspend_ack_n_out;
		endcase
	endfunction
	task automatic wait_on(input int w, input logic v, output int n);
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (pick(w) !== v && n < 200);
		if (pick(w) !== v) begin
			errors++;
			conclude();
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge clk_sys_in);
		psel_in <= 1'h1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_sys_in);
		penable_in <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (pready_out !== 1'h1 && n < 50);
		r = prdata_out;
		last_err = pslverr_out;
		psel_in <= 1'h0;
		penable_in <= 1'h0;
		if (pready_out !== 1'h1) begin
			errors++;
			conclude();
		end
	endtask
	task automatic do_reset(input logic [31:0] ctrl, output int n);
		logic [31:0] r;
		apb(1'h1, CTRL_OFFSET, ctrl, r);
		rst_cmd <= 1'h1;
		tick(6);
		apb(1'h1, CTRL_OFFSET, ctrl, r);
		rst_cmd <= 1'h0;
		wait_on(0, 1'h1, n);
		`CHK(fetch_address_out, FETCH_VECTOR)
		`CHK(exec_enable_out, 1'h1)
	endtask
	////////////////////////////////////////
	task automatic t_boot();
		logic [7:0] a [11] = '{ACCUM_OFFSET, DATA_D_OFFSET, SELECTOR_OFFSET,
			SEG_LIMIT_OFFSET, SEG_BASE_OFFSET, FETCH_OFFSET, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h40};
		logic [31:0] e [11] = '{ACCUM_PASS, {16'h0, DATA_D_BASE + {8'h0, REV}},
			{CODE_SELECTOR_INIT, DATA_SELECTOR_INIT}, {16'h0, SEG_LIMIT_INIT}, SEG_BASE_INIT,
			FETCH_VECTOR, {16'h0, NONCACHE_ONE_INIT}, {16'h0, NONCACHE_OTHER_INIT},
			{16'h0, NONCACHE_OTHER_INIT}, {16'h0, NONCACHE_OTHER_INIT}, 32'h0};
		logic [31:0] r;
		do_reset(32'h0, base_n);
		`CHK(base_n >= BASE && base_n <= BASE + 6, 1'h1)
		`CHK({real_mode_out, cache_enable_out, paging_enable_out}, 3'h4)
		for (int i = 0; i < 11; i++) begin
			apb(1'h0, a[i], 32'h0, r);
			`CHK(r, e[i])
			`CHK(last_err, i == 10)
		end
	endtask
	task automatic t_addr();
		logic [31:0] r;
		linear_addr_in <= 32'hFFF12345;
		code_cycle_in <= 1'h1;
		tick(2);
		`CHK(phys_addr_out, 32'hFFF12345)
		far_transfer_in <= 1'h1;
		tick(1);
		far_transfer_in <= 1'h0;
		tick(2);
		`CHK(phys_addr_out, 32'h00012345)
		code_cycle_in <= 1'h0;
		tick(2);
		`CHK(phys_addr_out, 32'hFFF12345)
		code_cycle_in <= 1'h1;
		apb(1'h1, CTRL_OFFSET, 32'h2, r);
		tick(2);
		`CHK(phys_addr_out, 32'hFFF12345)
	endtask
	task automatic t_reset_entry();
		logic [31:0] r;
		int ab = 0, inv = 0;
		apb(1'h1, CTRL_OFFSET, 32'h18, r);
		apb(1'h1, 8'h24, 32'h1234, r);
		`CHK({cache_enable_out, paging_enable_out}, 2'h3)
		rst_cmd <= 1'h1;
		repeat (8) begin
			@(posedge clk_sys_in);
			ab += bus_abort_out;
			inv += cache_invalidate_out;
		end
		`CHK(ab, 1)
		`CHK(inv, 1)
		`CHK({pipeline_flush_out, exec_enable_out, bus_start_enable_out}, 3'h4)
		`CHK({real_mode_out, cache_enable_out, paging_enable_out}, 3'h4)
		apb(1'h0, STATUS_OFFSET, 32'h0, r);
		`CHK({r[12:10], r[4:0]}, 8'h81)
		apb(1'h0, 8'h24, 32'h0, r);
		`CHK(r, 32'h0)
		do_reset(32'h0, ab);
	endtask
	task automatic t_selftest();
		logic [31:0] r;
		int n;
		do_reset(32'h1, n);
		`CHK(n - base_n, SELF)
		apb(1'h0, STATUS_OFFSET, 32'h0, r);
		`CHK(r[9], 1'h1)
		apb(1'h0, ACCUM_OFFSET, 32'h0, r);
		`CHK(r, ACCUM_PASS)
		selftest_pass_in <= 1'h0;
		do_reset(32'h1, n);
		`CHK(n - base_n, SELF)
		apb(1'h0, ACCUM_OFFSET, 32'h0, r);
		`CHK(r, ACCUM_FAIL)
		selftest_pass_in <= 1'h1;
		do_reset(32'h0, n);
	endtask
	// kind 0 by the request pin, 1 by the stop instruction, 2 by the control register
	task automatic t_suspend(input int kind);
		logic [31:0] r;
		int n;
		apb(1'h1, 8'h28, 32'hABCD, r);
		if (kind == 0) begin
			suspend_request_n_cmd <= 1'h1;
		end else if (kind == 1) begin
			halt_exec_in <= 1'h1;
			tick(1);
			halt_exec_in <= 1'h0;
		end else begin
			apb(1'h1, CTRL_OFFSET, 32'h4, r);
		end
		tick(6);
		`CHK({suspend_ack_n_out, core_hold_out, exec_enable_out}, 3'h6)
		core_idle_in <= 1'h1;
		wait_on(1, 1'h0, n);
		`CHK(n <= 3, 1'h1)
		apb(1'h0, STATUS_OFFSET, 32'h0, r);
		`CHK(r[4:0], 5'h10)
		run = 1'h0;
		#200;
		run = 1'h1;
		tick(1);
		`CHK(suspend_ack_n_out, 1'h0)
		suspend_request_n_cmd <= 1'h0;
		wake_in <= kind != 0;
		wait_on(1, 1'h1, n);
		wake_in <= 1'h0;
		core_idle_in <= 1'h0;
		tick(2);
		`CHK({suspend_ack_n_out, exec_enable_out, core_hold_out}, 3'h6)
		apb(1'h0, 8'h28, 32'h0, r);
		`CHK(r, 32'hABCD)
	endtask
	initial begin
		repeat (6) @(posedge clk_sys_in);
		resetn_in <= 1'h1;
		t_boot();
		t_addr();
		t_reset_entry();
		t_selftest();
		for (int k = 0; k < 3; k++) begin
			t_suspend(k);
		end
		conclude();
	end
endmodule
